/* tb.sv */
`timescale 1ns/1ps
module tb;
  logic        mclk, reset_n, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, src_sel;
  logic [2:0]  hsize;
  logic [15:0] timer_counter_value, m_act, m_buf;
  logic        count_down, update_event, trigger_edge, e;
  logic        timer_input_4, timer_input_3, internal_trigger_input;
  logic        channel4_reference, channel4_output, capture_event;
  logic        src_level, src_armed;
  int          num_errors, cmp_count, cap_n, cyc, n0, t, n, dv;
  logic [7:0]  offs [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
  logic [15:0] fmode [4] = '{16'h6C00, 16'h7C00, 16'h6800, 16'h0C00};
  logic [3:0]  fpre = 4'b1101;
  logic [3:0]  fexp = 4'b1110;
  logic [2:0]  ocm [4] = '{tch4_pkg::OC_FORCE_HI, tch4_pkg::OC_FORCE_LO,
                           tch4_pkg::OC_SET_MATCH, tch4_pkg::OC_CLR_MATCH};
  int          fnum [16] = '{1, 2, 4, 8, 6, 8, 6, 8, 6, 8, 5, 6, 8, 6, 8, 8};
  int          fdiv [16] = '{0, 0, 0, 0, 1, 1, 2, 2, 3, 3, 4, 4, 4, 5, 5, 5};

  tch4_channel u_tch4_channel (.mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .timer_counter_value(timer_counter_value),
    .count_down(count_down), .update_event(update_event), .trigger_edge(trigger_edge),
    .timer_input_4(timer_input_4), .timer_input_3(timer_input_3),
    .internal_trigger_input(internal_trigger_input), .channel4_reference(channel4_reference),
    .channel4_output(channel4_output), .capture_event(capture_event));

  tch4_source_model u_tch4_source_model (.mclk(mclk), .sel(src_sel), .level(src_level),
    .armed(src_armed), .timer_input_4(timer_input_4), .timer_input_3(timer_input_3),
    .internal_trigger_input(internal_trigger_input));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  // Sized for about 10k cycles of tests
  always @(posedge mclk)
  begin
    cyc++;
    if (capture_event === 1'b1)
      cap_n <= cap_n + 1;
    if (cyc == 60000)
    begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic chk_pin(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_pin

  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
  endtask : tick

  // Entered just after a rising edge; returns at the edge that ends the data phase
  task automatic ahb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    hsel <= 1'b1;
    haddr <= {24'h0, addr};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= tch4_pkg::SIZE_WORD;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wdata;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  // Passing through the output role clears prescaler and filter before the source moves
  task automatic set_in(input logic [1:0] sel, input logic [15:0] mode);
    ahb(1'b1, tch4_pkg::OFF_CTRL, 32'h0);
    ahb(1'b1, tch4_pkg::OFF_MODE, 32'h0);
    src_sel <= sel;
    ahb(1'b1, tch4_pkg::OFF_MODE, {16'h0, mode});
    ahb(1'b1, tch4_pkg::OFF_CTRL, 32'h1);
  endtask : set_in

  initial
  begin
    reset_n = 1'b0;
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    {timer_counter_value, count_down, update_event, trigger_edge} = '0;
    {src_sel, src_level, src_armed} = '0;
    void'($urandom(32'h47aa));
    tick(16);
    reset_n <= 1'b1;
    tick(1);
    foreach (offs[i])
    begin
      ahb(1'b0, offs[i], 32'h0);
      chk_word("reset read", 32'h0, rd);
    end
    ahb(1'b1, 8'h10, 32'hFFFFFFFF);
    ahb(1'b0, 8'h10, 32'h0);
    chk_word("unmapped read", 32'h0, rd);
    chk_pin("okay response", 1'b0, hresp);
    $display("test registers done");
    ahb(1'b1, tch4_pkg::OFF_MODE, 32'h6000);
    ahb(1'b0, tch4_pkg::OFF_MODE, 32'h0);
    chk_word("mode readback", 32'h6000, rd);
    ahb(1'b1, tch4_pkg::OFF_CMP, 32'h1234);
    m_act = 16'h1234;
    ahb(1'b0, tch4_pkg::OFF_STAT, 32'h0);
    chk_word("active compare", {16'h0, m_act}, {16'h0, rd[31:16]});
    ahb(1'b1, tch4_pkg::OFF_MODE, 32'h6800);
    ahb(1'b1, tch4_pkg::OFF_CMP, 32'h00F0);
    m_buf = 16'h00F0;
    ahb(1'b0, tch4_pkg::OFF_CMP, 32'h0);
    chk_word("buffer read", {16'h0, m_buf}, rd);
    ahb(1'b0, tch4_pkg::OFF_STAT, 32'h0);
    chk_word("active before update", {16'h0, m_act}, {16'h0, rd[31:16]});
    update_event <= 1'b1;
    tick(1);
    update_event <= 1'b0;
    m_act = m_buf;
    ahb(1'b0, tch4_pkg::OFF_STAT, 32'h0);
    chk_word("active after update", {16'h0, m_act}, {16'h0, rd[31:16]});
    $display("test compare buffer done");
    ahb(1'b1, tch4_pkg::OFF_CTRL, 32'h1);
    for (int i = 0; i < 20; i++)
    begin
      if (i == 10)
        ahb(1'b1, tch4_pkg::OFF_CTRL, 32'h3);
      timer_counter_value <= (i == 0 || i == 5) ? m_act :
                             (i == 1) ? m_act - 16'h1 : 16'($urandom_range(0, 16'h01E0));
      count_down <= (i >= 5 && i < 15);
      tick(2);
      e = count_down ? (timer_counter_value <= m_act) : (timer_counter_value < m_act);
      chk_pin("reference", e, channel4_reference);
      tick(1);
      chk_pin("output", e ^ (i >= 10), channel4_output);
    end
    $display("test pwm done");
    ahb(1'b1, tch4_pkg::OFF_CTRL, 32'h1);
    timer_counter_value <= 16'h0010;
    for (int i = 0; i < 4; i++)
    begin
      ahb(1'b1, tch4_pkg::OFF_MODE, {16'h0, fmode[i]});
      tick(3);
      trigger_edge <= 1'b1;
      tick(1);
      trigger_edge <= 1'b0;
      tick(2);
      chk_pin("reference before force", fpre[i], channel4_reference);
      tick(1);
      chk_pin("reference after trigger", fexp[i], channel4_reference);
    end
    $display("test fast trigger done");
    timer_counter_value <= m_act;
    for (int j = 0; j < 4; j++)
    begin
      ahb(1'b1, tch4_pkg::OFF_MODE, {17'h0, ocm[j], 12'h000});
      tick(2);
      chk_pin("compare mode level", !j[0], channel4_reference);
    end
    $display("test compare modes done");
    src_armed <= 1'b1;
    for (int d = 1; d < 4; d++)
    begin
      for (int p = 0; p < 4; p++)
      begin
        timer_counter_value <= 16'($urandom);
        set_in(2'(d), 16'((p << 10) | (d << 8)));
        tick(4);
        n0 = cap_n;
        repeat (8)
        begin
          src_level <= 1'b1;
          tick(4);
          src_level <= 1'b0;
          tick(4);
        end
        tick(4);
        chk_word("capture count", 32'(8 >> p), 32'(cap_n - n0));
        ahb(1'b0, tch4_pkg::OFF_STAT, 32'h0);
        chk_word("captured value", {16'h0, timer_counter_value}, {16'h0, rd[31:16]});
        chk_pin("output in input role", 1'b0, channel4_output);
      end
    end
    $display("test capture done");
    for (int c = 0; c < 16; c++)
    begin
      dv = 1 << fdiv[c];
      n = fnum[c];
      set_in(2'h1, 16'((c << 12) | 16'h0100));
      tick(n * dv * 2 + 8);
      n0 = cap_n;
      src_level <= 1'b1;
      tick(1);
      src_level <= 1'b0;
      tick((n + 1) * dv + 8);
      chk_word("glitch captures", (c == 0) ? 32'h1 : 32'h0, 32'(cap_n - n0));
      n0 = cap_n;
      t = 0;
      src_level <= 1'b1;
      while (cap_n == n0 && t < 600)
      begin
        tick(1);
        t++;
      end
      chk_pin("filter delay", 1'b1, t >= (n - 1) * dv && t <= (n + 1) * dv + 4);
      src_level <= 1'b0;
      tick(n * dv * 2 + 8);
    end
    $display("test filter done");
    wrap_up();
  end
endmodule : tb

/* tch4_channel.sv */
`timescale 1ns/1ps
// Overview of operation
// R01: Buffer off: compare writes go straight into the active compare register.
// R02: Buffer on: compare access hits buffer; buffer loads active register on update.
// R03: Software enables buffer in PWM modes unless one-pulse mode is set.
// R04: Fast off: output follows comparison even while trigger active.
// R05: Fast on: trigger edge forces compare level, three cycles later.
// R06: Fast enable works only in PWM mode 1 or 2.
// R07: Compare fields apply with direction 00; capture fields otherwise.
// R08: Filter passes a new level after N matching consecutive samples.
// R09: Filter codes 0000-0011 sample every clock; N of 1, 2, 4, 8.
// R10: Codes 0100-0101 sample clock/2, 0110-0111 clock/4; N of 6, 8.
// R11: Codes 1010-1100 sample clock/16 N 5,6,8; 1101-1110 clock/32 N 6,8.
// R12: Prescaler captures every 1, 2, 4 or 8 detected edges.
// R13: Direction 00 output, 01 input 4, 10 input 3, 11 internal trigger.
// R14: Software picks an internal trigger before choosing that capture source.
// R15: Software changes direction only while the channel is disabled.
// R16: PWM mode 1 counting up: reference active while counter below compare.
// R17: Codes 1000 and 1001 sample clock/8 with N of 6 and 8.
module tch4_channel (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Timer core
  input  wire logic [15:0] timer_counter_value,
  input  wire logic        count_down,
  input  wire logic        update_event,
  input  wire logic        trigger_edge,
  // Capture sources
  input  wire logic        timer_input_4,
  input  wire logic        timer_input_3,
  input  wire logic        internal_trigger_input,
  // Channel outputs
  output logic             channel4_reference,
  output logic             channel4_output,
  output logic             capture_event
);

  typedef struct packed {
    logic [15:0]                 mode;
    logic [15:0]                 cmp_buf;
    logic [15:0]                 cmp_act;
    logic                        en;
    logic                        pol;
    logic                        ref_lvl;
    logic                        out_lvl;
    logic                        prev_filt;
    logic                        cap_evt;
    logic [tch4_pkg::FAST_PIPE-1:0] fast_pipe;
    logic [2:0]                  psc_cnt;
    logic                        wr_pend;
    logic [tch4_pkg::ADDR_W-1:0] wr_addr;
    logic                        ready;
    logic [31:0]                 rdata;
  } tch4_state_t;

  tch4_state_t st_ff;
  tch4_state_t nxt_st;
  logic [1:0]  dir;
  logic        out_mode;
  logic [2:0]  oc_mode;
  logic        buf_en;
  logic        fast_en;
  logic        pwm;
  logic        fast_ok;
  logic [3:0]  filt_code;
  logic [1:0]  psc;
  logic [2:0]  ratio;
  logic        src;
  logic        filt;
  logic        edge_det;
  logic        match;
  logic        below;
  logic        above;
  logic        addr_ok;

  // Field views; output and input fields share bits, direction decides
  assign dir       = st_ff.mode[tch4_pkg::DIR_MSB:tch4_pkg::DIR_LSB];
  assign out_mode  = (dir == tch4_pkg::DIR_OUTPUT); // R07
  assign oc_mode   = st_ff.mode[tch4_pkg::OCM_MSB:tch4_pkg::OCM_LSB];
  assign buf_en    = st_ff.mode[tch4_pkg::OCBE_BIT];
  assign fast_en   = st_ff.mode[tch4_pkg::OCFE_BIT];
  assign filt_code = st_ff.mode[tch4_pkg::ICF_MSB:tch4_pkg::ICF_LSB];
  assign psc       = st_ff.mode[tch4_pkg::ICPSC_MSB:tch4_pkg::ICPSC_LSB];
  assign ratio     = 3'((4'h1 << psc) - 4'h1); // R12
  assign pwm       = (oc_mode == tch4_pkg::OC_PWM1) || (oc_mode == tch4_pkg::OC_PWM2);
  assign fast_ok   = out_mode && fast_en && pwm; // R06 R07

  // Capture source select
  always_comb
  begin
    case (dir) // R13
      tch4_pkg::DIR_TI4:  src = timer_input_4;
      tch4_pkg::DIR_TI3:  src = timer_input_3;
      tch4_pkg::DIR_INTERNAL_TRIGGER_INPUT: src = internal_trigger_input;
      default:            src = 1'b0;
    endcase
  end

  tch4_filter u_filter (
    .mclk        (mclk),
    .reset_n     (reset_n),
    .filter_code (filt_code),
    .active      (!out_mode),
    .raw_level   (src),
    .filt_level  (filt)
  );

  // Polarity picks the capture edge: 0 rising, 1 falling
  assign edge_det = !out_mode && (filt != st_ff.prev_filt) && (filt != st_ff.pol);
  assign match    = (timer_counter_value == st_ff.cmp_act);
  assign below    = (timer_counter_value < st_ff.cmp_act);
  assign above    = (timer_counter_value > st_ff.cmp_act);
  assign addr_ok  = hready && hsel && htrans[1] && (hsize == tch4_pkg::SIZE_WORD);

  always_comb
  begin
    nxt_st         = st_ff;
    nxt_st.cap_evt = 1'b0;
    nxt_st.wr_pend = 1'b0;
    nxt_st.ready   = 1'b1;
    // Write data phase
    if (st_ff.wr_pend)
    begin
      case (st_ff.wr_addr)
        tch4_pkg::OFF_MODE:
          nxt_st.mode = hwdata[15:0];
        tch4_pkg::OFF_CMP:
        begin
          if (out_mode && buf_en)
            nxt_st.cmp_buf = hwdata[15:0]; // R02
          else
          begin
            nxt_st.cmp_act = hwdata[15:0]; // R01
            nxt_st.cmp_buf = hwdata[15:0];
          end
        end
        tch4_pkg::OFF_CTRL:
        begin
          nxt_st.en  = hwdata[tch4_pkg::CTRL_EN_BIT];
          nxt_st.pol = hwdata[tch4_pkg::CTRL_POL_BIT];
        end
        default:
          nxt_st.mode = st_ff.mode;
      endcase
    end
    // Buffered compare value moves over only at the update event
    if (update_event && out_mode && buf_en)
      nxt_st.cmp_act = nxt_st.cmp_buf; // R02
    // Fast path: the trigger is armed only when fast mode is legal
    nxt_st.fast_pipe = {st_ff.fast_pipe[tch4_pkg::FAST_PIPE-2:0], trigger_edge && fast_ok}; // R05 R06
    // Capture with event prescaler
    nxt_st.prev_filt = filt;
    if (out_mode)
      nxt_st.psc_cnt = '0;
    else if (edge_det)
    begin
      if (st_ff.psc_cnt == ratio) // R12
      begin
        nxt_st.psc_cnt = '0;
        nxt_st.cap_evt = 1'b1;
        nxt_st.cmp_act = timer_counter_value;
      end
      else
        nxt_st.psc_cnt = st_ff.psc_cnt + 3'h1;
    end
    // Reference level
    if (!out_mode)
      nxt_st.ref_lvl = 1'b0; // R07
    else if (st_ff.fast_pipe[tch4_pkg::FAST_PIPE-1] && pwm)
      nxt_st.ref_lvl = (oc_mode == tch4_pkg::OC_PWM2); // R05
    else
    begin
      case (oc_mode) // R04
        tch4_pkg::OC_FROZEN:    nxt_st.ref_lvl = st_ff.ref_lvl;
        tch4_pkg::OC_SET_MATCH: nxt_st.ref_lvl = match ? 1'b1 : st_ff.ref_lvl;
        tch4_pkg::OC_CLR_MATCH: nxt_st.ref_lvl = match ? 1'b0 : st_ff.ref_lvl;
        tch4_pkg::OC_TOGGLE:    nxt_st.ref_lvl = match ? !st_ff.ref_lvl : st_ff.ref_lvl;
        tch4_pkg::OC_FORCE_LO:  nxt_st.ref_lvl = 1'b0;
        tch4_pkg::OC_FORCE_HI:  nxt_st.ref_lvl = 1'b1;
        tch4_pkg::OC_PWM1:      nxt_st.ref_lvl = count_down ? !above : below; // R16
        tch4_pkg::OC_PWM2:      nxt_st.ref_lvl = count_down ? above : !below;
        default:                nxt_st.ref_lvl = st_ff.ref_lvl;
      endcase
    end
    // Pin level lags the reference by one clock so that it is a plain flop
    nxt_st.out_lvl = st_ff.en && out_mode && (st_ff.ref_lvl ^ st_ff.pol); // R07
    // Address phase; reads see the value after any write in the same cycle
    if (addr_ok)
    begin
      if (hwrite)
      begin
        nxt_st.wr_pend = 1'b1;
        nxt_st.wr_addr = haddr[tch4_pkg::ADDR_W-1:0];
      end
      else
      begin
        case (haddr[tch4_pkg::ADDR_W-1:0])
          tch4_pkg::OFF_MODE: nxt_st.rdata = {16'h0000, nxt_st.mode};
          tch4_pkg::OFF_CMP:  nxt_st.rdata = {16'h0000, (out_mode && buf_en) ? nxt_st.cmp_buf : nxt_st.cmp_act};
          tch4_pkg::OFF_CTRL: nxt_st.rdata = {30'h00000000, nxt_st.pol, nxt_st.en};
          tch4_pkg::OFF_STAT: nxt_st.rdata = {nxt_st.cmp_act, 13'h0000, st_ff.prev_filt, st_ff.out_lvl,
                                              st_ff.ref_lvl};
          default:            nxt_st.rdata = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_ff       <= '0;
      st_ff.mode  <= tch4_pkg::MODE_RESET;
      st_ff.ready <= 1'b1;
    end
    else
      st_ff <= nxt_st;
  end

  assign hreadyout          = st_ff.ready;
  assign hresp              = st_ff.cap_evt & 1'b0;
  assign hrdata             = st_ff.rdata;
  assign channel4_reference = st_ff.ref_lvl;
  assign channel4_output    = st_ff.out_lvl;
  assign capture_event      = st_ff.cap_evt;

  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence s_cmp_write;
    st_ff.wr_pend && (st_ff.wr_addr == tch4_pkg::OFF_CMP);
  endsequence

  sequence s_fast_trig;
    trigger_edge && fast_ok;
  endsequence

  chk_direct_write: assert property (s_cmp_write and out_mode && !buf_en && !update_event // R01
                                     |=> st_ff.cmp_act == $past(hwdata[15:0]))
    else $error("unbuffered compare write not applied");
  chk_buffer_load: assert property (update_event && out_mode && buf_en && !st_ff.wr_pend // R02
                                    |=> st_ff.cmp_act == $past(st_ff.cmp_buf))
    else $error("buffer not loaded on update event");
  chk_fast_latency: assert property (s_fast_trig ##1 (pwm && out_mode)[*2] // R05
                                     |=> channel4_reference == (oc_mode == tch4_pkg::OC_PWM2))
    else $error("fast trigger did not force compare level in three cycles");
  chk_no_force: assert property (st_ff.fast_pipe[tch4_pkg::FAST_PIPE-1] |-> $past(fast_ok, 2)) // R04 R06
    else $error("forced level without fast pwm mode");
  chk_pwm1_level: assert property (out_mode && oc_mode == tch4_pkg::OC_PWM1 && !count_down // R16
                                   && !st_ff.fast_pipe[tch4_pkg::FAST_PIPE-1] |=> channel4_reference == $past(below))
    else $error("pwm mode 1 level wrong");
  chk_output_gate: assert property (!out_mode || !st_ff.en |=> !channel4_output) // R07
    else $error("output driven while input or disabled");
  chk_capture_step: assert property (capture_event |-> $past(edge_det) && $past(st_ff.psc_cnt) == $past(ratio)) // R12
    else $error("capture off prescaler step");
  chk_capture_value: assert property (capture_event |-> st_ff.cmp_act == $past(timer_counter_value)) // R13
    else $error("capture value not counter");

  // A forced fast level masks the comparison for one cycle, so it is left out here
  sequence s_cmp_role;
    out_mode && !count_down && !st_ff.fast_pipe[tch4_pkg::FAST_PIPE-1];
  endsequence

  sequence s_cap_role;
    !out_mode;
  endsequence

  chk_pwm2_level: assert property (s_cmp_role and oc_mode == tch4_pkg::OC_PWM2 // R04
                                   |=> channel4_reference == !$past(below))
    else $error("pwm mode 2 level wrong");
  chk_pwm1_down: assert property (out_mode && oc_mode == tch4_pkg::OC_PWM1 && count_down // R04
                                  && !st_ff.fast_pipe[tch4_pkg::FAST_PIPE-1]
                                  |=> channel4_reference == !$past(above))
    else $error("pwm mode 1 down level wrong");
  chk_fast_ignored: assert property (trigger_edge && !fast_ok |=> !st_ff.fast_pipe[0]) // R06
    else $error("trigger armed outside fast pwm mode");
  chk_output_follow: assert property (out_mode && st_ff.en // R07
                                      |=> channel4_output == ($past(st_ff.ref_lvl) ^ $past(st_ff.pol)))
    else $error("output not reference with polarity");
  chk_input_ref: assert property (s_cap_role |=> !channel4_reference) // R07
    else $error("reference active in input role");
  chk_output_no_capture: assert property (out_mode |=> !capture_event) // R07
    else $error("capture taken in output role");
  chk_prescale_clear: assert property (out_mode |=> st_ff.psc_cnt == '0) // R07 R12
    else $error("prescaler not cleared in output role");
  chk_capture_rate: assert property (edge_det && st_ff.psc_cnt != ratio |=> !capture_event) // R12
    else $error("capture before prescaler count reached");
  chk_buffer_hold: assert property (out_mode && buf_en && !update_event |=> $stable(st_ff.cmp_act)) // R02
    else $error("active compare moved without update event");
  chk_buffer_write: assert property (s_cmp_write and out_mode && buf_en // R02
                                     |=> st_ff.cmp_buf == $past(hwdata[15:0]))
    else $error("buffered compare write not stored");

endmodule : tch4_channel

/* tch4_filter.sv */
`timescale 1ns/1ps
module tch4_filter (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       reset_n,
  // Configuration
  input  wire logic [3:0] filter_code,
  input  wire logic       active,
  // Level in and out
  input  wire logic       raw_level,
  output logic            filt_level
);

  typedef struct packed {
    logic [tch4_pkg::FDIV_CNT_W-1:0] div_cnt;
    logic [tch4_pkg::FN_W-1:0]       run_cnt;
    logic                            level;
  } tch4_filt_state_t;

  tch4_filt_state_t st_ff;
  tch4_filt_state_t nxt_st;
  logic [6:0]                        entry;
  logic [tch4_pkg::FDIV_W-1:0]       div_log2;
  logic [tch4_pkg::FN_W-1:0]         need_n;
  logic [tch4_pkg::FDIV_CNT_W-1:0]   div_mask;
  logic                              sample;

  assign entry    = tch4_pkg::FILT_TAB[filter_code];
  assign div_log2 = entry[tch4_pkg::FN_W+tch4_pkg::FDIV_W-1:tch4_pkg::FN_W];
  assign need_n   = entry[tch4_pkg::FN_W-1:0];
  // Free running divider; slow rates are a mask on it, so no extra counter
  assign div_mask = (tch4_pkg::FDIV_CNT_W'(1) << div_log2) - tch4_pkg::FDIV_CNT_W'(1);
  assign sample   = active && ((st_ff.div_cnt & div_mask) == '0); // R09 R10 R11 R17

  always_comb
  begin
    nxt_st         = st_ff;
    nxt_st.div_cnt = st_ff.div_cnt + tch4_pkg::FDIV_CNT_W'(1);
    if (!active)
    begin
      nxt_st.run_cnt = '0;
      nxt_st.level   = raw_level;
    end
    else if (sample)
    begin
      if (raw_level == st_ff.level)
        nxt_st.run_cnt = '0;
      else if (st_ff.run_cnt + tch4_pkg::FN_W'(1) >= need_n) // R08
      begin
        nxt_st.level   = raw_level;
        nxt_st.run_cnt = '0;
      end
      else
        nxt_st.run_cnt = st_ff.run_cnt + tch4_pkg::FN_W'(1);
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign filt_level = st_ff.level;

  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);

  chk_filter_sample: assert property (active && $past(active) && $changed(st_ff.level) |-> $past(sample)) // R08
    else $error("filter level moved off a sample");
  chk_filter_count: assert property (active && $past(active) && $stable(filter_code) && $changed(st_ff.level)
                                     |-> $past(st_ff.run_cnt) == need_n - tch4_pkg::FN_W'(1)) // R08
    else $error("filter level moved before N samples");

endmodule : tch4_filter

/* tch4_pkg.sv */
package tch4_pkg;

  // AHB-Lite decode
  localparam int unsigned ADDR_W     = 8;
  localparam logic [7:0]  OFF_MODE   = 8'h00;
  localparam logic [7:0]  OFF_CMP    = 8'h04;
  localparam logic [7:0]  OFF_CTRL   = 8'h08;
  localparam logic [7:0]  OFF_STAT   = 8'h0C;
  localparam logic [2:0]  SIZE_WORD  = 3'h2;

  // Mode register layout, output role
  localparam int unsigned OCM_LSB    = 12;
  localparam int unsigned OCM_MSB    = 14;
  localparam int unsigned OCBE_BIT   = 11;
  localparam int unsigned OCFE_BIT   = 10;
  // Mode register layout, input role
  localparam int unsigned ICF_LSB    = 12;
  localparam int unsigned ICF_MSB    = 15;
  localparam int unsigned ICPSC_LSB  = 10;
  localparam int unsigned ICPSC_MSB  = 11;
  // Direction field, both roles
  localparam int unsigned DIR_LSB    = 8;
  localparam int unsigned DIR_MSB    = 9;
  localparam logic [15:0] MODE_RESET = 16'h0000;

  // Control register layout
  localparam int unsigned CTRL_EN_BIT  = 0;
  localparam int unsigned CTRL_POL_BIT = 1;

  // Direction select codes
  localparam logic [1:0] DIR_OUTPUT = 2'h0;
  localparam logic [1:0] DIR_TI4    = 2'h1;
  localparam logic [1:0] DIR_TI3    = 2'h2;
  localparam logic [1:0] DIR_INTERNAL_TRIGGER_INPUT   = 2'h3;

  // Output compare modes
  localparam logic [2:0] OC_FROZEN    = 3'h0;
  localparam logic [2:0] OC_SET_MATCH = 3'h1;
  localparam logic [2:0] OC_CLR_MATCH = 3'h2;
  localparam logic [2:0] OC_TOGGLE    = 3'h3;
  localparam logic [2:0] OC_FORCE_LO  = 3'h4;
  localparam logic [2:0] OC_FORCE_HI  = 3'h5;
  localparam logic [2:0] OC_PWM1      = 3'h6;
  localparam logic [2:0] OC_PWM2      = 3'h7;

  // Trigger to reference latency with fast enable, in clock cycles
  localparam int unsigned FAST_LATENCY = 3;
  localparam int unsigned FAST_PIPE    = FAST_LATENCY - 1;

  // Filter table per code: {log2 of sample divider, samples needed}
  localparam int unsigned FDIV_W = 3;
  localparam int unsigned FN_W   = 4;
  localparam logic [6:0] FILT_TAB [16] = '{
    7'h01, 7'h02, 7'h04, 7'h08, 7'h16, 7'h18, 7'h26, 7'h28,
    7'h36, 7'h38, 7'h45, 7'h46, 7'h48, 7'h56, 7'h58, 7'h58
  };
  localparam int unsigned FDIV_CNT_W = 5;

endpackage : tch4_pkg

/* tch4_source_model.sv */
`timescale 1ns/1ps
module tch4_source_model (
  // Clock
  input  wire logic       mclk,
  // Control from the bench
  input  wire logic [1:0] sel,
  input  wire logic       level,
  input  wire logic       armed,
  // Capture sources
  output logic            timer_input_4,
  output logic            timer_input_3,
  output logic            internal_trigger_input
);
  logic noise;

  initial
  begin
    noise = 1'b0;
    timer_input_4 = 1'b0;
    timer_input_3 = 1'b0;
    internal_trigger_input = 1'b0;
  end

  // Unselected sources toggle every cycle (internal trigger only while armed), so a wrong mapping shows up as extra captures
  always @(posedge mclk)
  begin
    noise <= ~noise;
    timer_input_4 <= (sel == 2'h1) ? level : ~noise;
    timer_input_3 <= (sel == 2'h2) ? level : ~noise;
    internal_trigger_input <= armed & ((sel == 2'h3) ? level : ~noise);
  end
endmodule : tch4_source_model
